//--- src/fifo_host.sv
/*
  Host controller for one 9-bit asynchronous FIFO channel: drives the strobes, the clear
  and retransmit pins, and the data bus, watching the device flags before each strobe.
  Assumes software on AHB-Lite and a device whose flags are asynchronous to hclk.
*/
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// How it works
// RULE_01: Expansion input is driven low in single-device configuration.
// RULE_02: In a chain, first_load_select is driven low on the first device only.
// RULE_03: Devices other than the first see first_load_select held high.
// RULE_04: Each expansion output feeds the next expansion input; board wiring.
// RULE_05: Composite full and empty are formed by combining every device's flags; the host takes one full_flag and one empty_flag and combines nothing.
// RULE_06: Retransmit is refused in depth mode; half-full is ignored there.
// RULE_07: Width-expanded devices share controls; one flag set describes them all.
// RULE_08: Writes watch full_flag; reads watch empty_flag before strobing.
// RULE_09: A read held low over an empty device waits for its flow-through word.
// RULE_10: Read data is sampled before the read strobe rises.
// RULE_11: Empty flag may pulse high briefly during read flow-through.
// RULE_12: Write flow-through: full may drop then rise while store is low.
// RULE_13: Write data is held stable until after the store strobe rises.
// RULE_14: The store strobe only toggles while full_flag is deasserted.
// RULE_15: Clear drives clear_in_n low with expansion low; both pointers zero.
// RULE_16: Retransmit pulses retransmit_strobe low with clear_in_n high.
// RULE_17: Strobes are issued only while the matching flag is high.
// RULE_18: Clear in depth mode acts whatever first_load_select holds.
// RULE_19: Full low means no more stores are issued.
// RULE_20: Empty low means no more fetches are issued.
// RULE_21: Half-full flag is reported to software in single mode.
// RULE_22: Expansion pulses pass between devices, not through the host.
// RULE_23: In a chain the shared strobes go to all devices; tokens pick one.
module fifo_host #(
  parameter int unsigned DATA_W = fifo_host_pkg::DATA_W
) (
  // AHB-Lite slave.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device control pins.
  output logic store_pulse_n,
  output logic fetch_pulse_n,
  output logic clear_in_n,
  output logic retransmit_strobe,
  output logic first_load_select,
  output logic expansion_in,
  // Device data pins.
  output logic [DATA_W-1:0] dev_din,
  input wire logic [DATA_W-1:0] dev_dout,
  // Device flags, active low.
  input wire logic full_flag,
  input wire logic empty_flag,
  input wire logic half_full_flag
);
  if (DATA_W < 1 || DATA_W > 16) begin : g_bad
    $error("DATA_W must be 1 to 16");
  end

  logic [2:0] flag_s;
  logic [DATA_W-1:0] dout_s;
  logic ph_wr_q, ph_rd_q;
  logic [3:0] ph_addr_q;
  logic depth_q, first_q, refused_q, rvalid_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  fifo_host_pkg::seq_state_t state_q;
  fifo_host_pkg::op_t op_q;
  logic [fifo_host_pkg::CNT_W-1:0] cnt_q;
  logic go_q;
  fifo_host_pkg::op_t go_op_q;

  pin_sync #(.WIDTH(3), .INIT(3'h0)) u_flag_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({half_full_flag, full_flag, empty_flag}), // RULE_05 RULE_07
    .sync_out(flag_s)
  );
  pin_sync #(.WIDTH(DATA_W), .INIT('0)) u_data_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(dev_dout),
    .sync_out(dout_s)
  );

  function automatic logic [fifo_host_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = fifo_host_pkg::CNT_W'(n - 1);
  endfunction : cyc

  // Bus address phase capture; the slave is always ready with OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_addr_q <= 4'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      ph_wr_q <= hsel && htrans[1] && hwrite;
      ph_rd_q <= hsel && htrans[1] && !hwrite;
      ph_addr_q <= haddr[3:0];
    end
  end

  // Control writes and command launch.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      depth_q <= fifo_host_pkg::CTRL_RESET[0];
      first_q <= fifo_host_pkg::CTRL_RESET[1];
      wdata_q <= '0;
      go_q <= 1'b0;
      go_op_q <= fifo_host_pkg::OP_WRITE;
      refused_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (ph_wr_q && ph_addr_q == fifo_host_pkg::OFS_WDATA) begin
        wdata_q <= hwdata[DATA_W-1:0];
      end
      if (ph_wr_q && ph_addr_q == fifo_host_pkg::OFS_CTRL) begin
        depth_q <= hwdata[fifo_host_pkg::CTRL_DEPTH];
        first_q <= hwdata[fifo_host_pkg::CTRL_FIRST];
        if (state_q != fifo_host_pkg::ST_IDLE || go_q) begin
          refused_q <= |hwdata[3:0];
        end else if (hwdata[fifo_host_pkg::CTRL_CLEAR]) begin
          go_q <= 1'b1; // RULE_15 RULE_18
          go_op_q <= fifo_host_pkg::OP_CLEAR;
          refused_q <= 1'b0;
        end else if (hwdata[fifo_host_pkg::CTRL_RETX]) begin
          go_q <= !hwdata[fifo_host_pkg::CTRL_DEPTH]; // RULE_06
          go_op_q <= fifo_host_pkg::OP_RETX;
          refused_q <= hwdata[fifo_host_pkg::CTRL_DEPTH];
        end else if (hwdata[fifo_host_pkg::CTRL_WRITE]) begin
          go_q <= flag_s[1]; // RULE_08 RULE_14 RULE_19
          go_op_q <= fifo_host_pkg::OP_WRITE;
          refused_q <= !flag_s[1];
        end else if (hwdata[fifo_host_pkg::CTRL_READ]) begin
          go_q <= flag_s[0]; // RULE_08 RULE_17 RULE_20
          go_op_q <= fifo_host_pkg::OP_READ;
          refused_q <= !flag_s[0];
        end
      end
    end
  end

  // Pin sequencer: low phase, high phase, recovery.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= fifo_host_pkg::ST_IDLE;
      op_q <= fifo_host_pkg::OP_WRITE;
      cnt_q <= '0;
      store_pulse_n <= 1'b1;
      fetch_pulse_n <= 1'b1;
      clear_in_n <= 1'b1;
      retransmit_strobe <= 1'b1;
      dev_din <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      if (ph_rd_q && ph_addr_q == fifo_host_pkg::OFS_RDATA) begin
        rvalid_q <= 1'b0;
      end
      case (state_q)
        fifo_host_pkg::ST_IDLE: begin
          if (go_q) begin
            op_q <= go_op_q;
            state_q <= fifo_host_pkg::ST_LOW;
            case (go_op_q)
              fifo_host_pkg::OP_WRITE: begin
                dev_din <= wdata_q;
                store_pulse_n <= 1'b0; // RULE_14
                cnt_q <= cyc(fifo_host_pkg::STROBE_LOW_CYC);
              end
              fifo_host_pkg::OP_READ: begin
                fetch_pulse_n <= 1'b0; // RULE_20
                cnt_q <= cyc(fifo_host_pkg::STROBE_LOW_CYC + 2);
              end
              fifo_host_pkg::OP_CLEAR: begin
                clear_in_n <= 1'b0; // RULE_15 RULE_18
                cnt_q <= cyc(fifo_host_pkg::CLEAR_LOW_CYC);
              end
              default: begin
                retransmit_strobe <= 1'b0; // RULE_16
                cnt_q <= cyc(fifo_host_pkg::STROBE_LOW_CYC);
              end
            endcase
          end
        end
        fifo_host_pkg::ST_LOW: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            if (op_q == fifo_host_pkg::OP_READ) begin
              rdata_q <= dout_s; // RULE_10
              rvalid_q <= 1'b1;
            end
            store_pulse_n <= 1'b1; // RULE_13
            fetch_pulse_n <= 1'b1;
            clear_in_n <= 1'b1;
            retransmit_strobe <= 1'b1;
            cnt_q <= cyc(fifo_host_pkg::STROBE_HIGH_CYC);
            state_q <= fifo_host_pkg::ST_HIGH;
          end
        end
        fifo_host_pkg::ST_HIGH: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= cyc(fifo_host_pkg::RECOVER_CYC);
            state_q <= fifo_host_pkg::ST_REC;
          end
        end
        fifo_host_pkg::ST_REC: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            state_q <= fifo_host_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= fifo_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // first_load_select follows the control register and expansion_in is held low; both registered to stay glitch free.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_load_select <= 1'b1;
      expansion_in <= 1'b0;
    end else begin
      first_load_select <= !(depth_q && first_q); // RULE_02 RULE_03 RULE_18
      expansion_in <= 1'b0; // RULE_01 RULE_04
    end
  end

  // Read data mux, registered so hrdata comes from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[3:0])
        fifo_host_pkg::OFS_CTRL: hrdata <= {26'h0, first_q, depth_q, 4'h0};
        fifo_host_pkg::OFS_WDATA: hrdata <= 32'(wdata_q);
        fifo_host_pkg::OFS_RDATA: hrdata <= 32'(rdata_q);
        fifo_host_pkg::OFS_STATUS: hrdata <= 32'({rvalid_q, refused_q,
            flag_s[2] | depth_q, flag_s[1], flag_s[0],
            state_q != fifo_host_pkg::ST_IDLE || go_q}); // RULE_21 RULE_06
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions.
  property p_store_needs_room;
    @(posedge hclk) disable iff (!hresetn)
      $fell(store_pulse_n) |-> $past(flag_s[1], 2);
  endproperty
  a_store_needs_room: assert property (p_store_needs_room) else $error("store while full"); // RULE_14

  property p_fetch_needs_data;
    @(posedge hclk) disable iff (!hresetn)
      $fell(fetch_pulse_n) |-> $past(flag_s[0], 2);
  endproperty
  a_fetch_needs_data: assert property (p_fetch_needs_data) else $error("fetch while empty"); // RULE_20

  property p_data_stable;
    @(posedge hclk) disable iff (!hresetn)
      !store_pulse_n |=> $stable(dev_din);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("write data moved"); // RULE_13

  property p_clear_width;
    @(posedge hclk) disable iff (!hresetn)
      $fell(clear_in_n) |-> !clear_in_n [*7];
  endproperty
  a_clear_width: assert property (p_clear_width) else $error("clear too short"); // RULE_15

  property p_retx_clear_high;
    @(posedge hclk) disable iff (!hresetn)
      !retransmit_strobe |-> clear_in_n && !depth_q;
  endproperty
  a_retx_clear_high: assert property (p_retx_clear_high) else $error("bad retransmit"); // RULE_16

  property p_single_mode;
    @(posedge hclk) disable iff (!hresetn)
      ##1 !expansion_in;
  endproperty
  a_single_mode: assert property (p_single_mode) else $error("expansion_in high"); // RULE_01

  property p_one_strobe;
    @(posedge hclk) disable iff (!hresetn)
      $onehot0({!store_pulse_n, !fetch_pulse_n, !clear_in_n, !retransmit_strobe});
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes low"); // RULE_17

  property p_read_captured;
    @(posedge hclk) disable iff (!hresetn)
      $rose(fetch_pulse_n) |-> rvalid_q ##0 rdata_q == $past(dout_s);
  endproperty
  a_read_captured: assert property (p_read_captured) else $error("read data lost"); // RULE_10

  property p_write_done;
    @(posedge hclk) disable iff (!hresetn)
      $fell(store_pulse_n) |-> ##[1:12] store_pulse_n;
  endproperty
  a_write_done: assert property (p_write_done) else $error("store stuck low"); // RULE_13

  c_write: cover property (@(posedge hclk) $fell(store_pulse_n));
  c_read: cover property (@(posedge hclk) $fell(fetch_pulse_n));
  c_clear: cover property (@(posedge hclk) $fell(clear_in_n));
  c_retx: cover property (@(posedge hclk) $fell(retransmit_strobe));
endmodule : fifo_host

//--- common/fifo_host_pkg.sv
/*
  Constants shared by the asynchronous FIFO host controller: register offsets, field
  positions, reset values and strobe timing counts.
  Assumes a 200 MHz hclk and software access over AHB-Lite.
*/
package fifo_host_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Strobe low and high times and the reset hold, in ns.
  localparam int unsigned STROBE_LOW_NS = 25;
  localparam int unsigned STROBE_HIGH_NS = 15;
  localparam int unsigned CLEAR_LOW_NS = 35;
  localparam int unsigned RECOVER_NS = 15;
  localparam int unsigned STROBE_LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) /
                                           CLK_PERIOD_PS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) /
                                            CLK_PERIOD_PS;
  localparam int unsigned CLEAR_LOW_CYC = (CLEAR_LOW_NS * 1000 + CLK_PERIOD_PS - 1) /
                                          CLK_PERIOD_PS;
  localparam int unsigned RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) /
                                        CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned DATA_W = 9;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_WDATA = 4'h4;
  localparam logic [3:0] OFS_RDATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Control register fields; command bits are self-clearing.
  localparam int unsigned CTRL_WRITE = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_CLEAR = 2;
  localparam int unsigned CTRL_RETX = 3;
  localparam int unsigned CTRL_DEPTH = 4;
  localparam int unsigned CTRL_FIRST = 5;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status register fields.
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_EMPTY = 1;
  localparam int unsigned ST_FULL = 2;
  localparam int unsigned ST_HALF = 3;
  localparam int unsigned ST_REFUSED = 4;
  localparam int unsigned ST_RVALID = 5;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_REC = 3'b011
  } seq_state_t;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_CLEAR = 2'b10,
    OP_RETX = 2'b11
  } op_t;
endpackage : fifo_host_pkg

//--- src/pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to hclk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Pins in and synchronised out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= INIT;
      sync_out <= INIT;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync

//--- sim/fifo_dev_model.sv
/*
  Behavioural model of one 9-bit asynchronous FIFO channel with active-low flags.
  Assumes a host that keeps only one strobe low at a time and a shallow DEPTH.
*/
`timescale 1ns/1ps
module fifo_dev_model #(
  parameter int DEPTH = 8
) (
  // Strobes and mode pins.
  input wire logic store_pulse_n,
  input wire logic fetch_pulse_n,
  input wire logic clear_in_n,
  input wire logic retransmit_strobe,
  input wire logic first_load_select,
  input wire logic expansion_in,
  // Data.
  input wire logic [8:0] dev_din,
  output logic [8:0] dev_dout,
  // Flags, active low.
  output logic full_flag,
  output logic empty_flag,
  output logic half_full_flag
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q = 9'h0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  logic half_n = 1'b1;
  logic wr_ok;
  logic rd_ok;
  // One model stands for the whole array, so its flags describe every slice.
  assign full_flag = (cnt != DEPTH);
  assign empty_flag = (cnt != 0);
  assign half_full_flag = half_n;
  // Released outputs show the inverse so a stale word can never pass as fresh.
  assign dev_dout = fetch_pulse_n ? ~q : q;
  always @(negedge clear_in_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    half_n = 1'b1;
  end
  always @(negedge retransmit_strobe) begin
    if (clear_in_n && expansion_in == 1'b0) begin
      rp = 0;
      cnt = wp;
      half_n = (cnt <= DEPTH / 2);
    end
  end
  always @(negedge store_pulse_n) begin
    wr_ok = clear_in_n && (cnt < DEPTH);
    if (wr_ok && cnt >= DEPTH / 2) begin
      half_n = 1'b0;
    end
  end
  always @(posedge store_pulse_n) begin
    if (wr_ok) begin
      mem[wp] = dev_din;
      wp = (wp + 1) % DEPTH;
      cnt = cnt + 1;
      // A fetch already held low over an empty array takes this word at once.
      if (!fetch_pulse_n && !rd_ok) begin
        q = mem[rp];
        rd_ok = 1'b1;
      end
    end
  end
  always @(negedge fetch_pulse_n) begin
    rd_ok = clear_in_n && (cnt > 0);
    if (rd_ok) begin
      q = mem[rp];
    end
  end
  always @(posedge fetch_pulse_n) begin
    if (rd_ok) begin
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
      if (cnt <= DEPTH / 2) begin
        half_n = 1'b1;
      end
      // A store held low over a full array claims the freed location.
      if (!store_pulse_n && !wr_ok) begin
        wr_ok = clear_in_n;
      end
    end
  end
endmodule : fifo_dev_model

//--- sim/fifo_host_tb.sv
/*
  Self-checking bench for the FIFO host controller, with a device model on its pins.
  Assumes zero-wait AHB-Lite slave behaviour and the register map of the shared package.
*/
`timescale 1ns/1ps
module fifo_host_tb;
  localparam int DEPTH = 8;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic store_pulse_n, fetch_pulse_n, clear_in_n, retransmit_strobe;
  logic first_load_select, expansion_in, full_flag, empty_flag, half_full_flag;
  logic [8:0] dev_din;
  logic [8:0] dev_dout;
  logic [31:0] mode;
  logic [31:0] st;
  int fails = 0;
  int samples_checked = 0;
  int n_st = 0;
  int n_fe = 0;
  int n_cl = 0;
  int n_retx = 0;
  fifo_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .store_pulse_n(store_pulse_n),
    .fetch_pulse_n(fetch_pulse_n), .clear_in_n(clear_in_n),
    .retransmit_strobe(retransmit_strobe), .first_load_select(first_load_select),
    .expansion_in(expansion_in), .dev_din(dev_din), .dev_dout(dev_dout),
    .full_flag(full_flag), .empty_flag(empty_flag), .half_full_flag(half_full_flag));
  fifo_dev_model #(.DEPTH(DEPTH)) dev (.store_pulse_n(store_pulse_n),
    .fetch_pulse_n(fetch_pulse_n), .clear_in_n(clear_in_n),
    .retransmit_strobe(retransmit_strobe), .first_load_select(first_load_select),
    .expansion_in(expansion_in), .dev_din(dev_din), .dev_dout(dev_dout),
    .full_flag(full_flag), .empty_flag(empty_flag), .half_full_flag(half_full_flag));
  always @(negedge store_pulse_n) n_st++;
  always @(negedge fetch_pulse_n) n_fe++;
  always @(negedge clear_in_n) n_cl++;
  always @(negedge retransmit_strobe) n_retx++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Overlapping strobes would corrupt both pointers on the device.
  always @(posedge hclk) begin
    if (hresetn && (32'(!store_pulse_n) + 32'(!fetch_pulse_n) + 32'(!clear_in_n)
        + 32'(!retransmit_strobe)) > 1) begin
      chk(32'h1, 32'h0);
    end
  end
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {28'h0, a};
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic cmd(input int bit_no);
    logic [31:0] d;
    int k;
    xfer(1'b1, fifo_host_pkg::OFS_CTRL, mode | (32'h1 << bit_no), d);
    repeat (3) @(posedge hclk);
    k = 0;
    do begin
      xfer(1'b0, fifo_host_pkg::OFS_STATUS, 32'h0, st);
      k++;
    end while (st[fifo_host_pkg::ST_BUSY] !== 1'b0 && k < 100);
    chk(32'(st[fifo_host_pkg::ST_BUSY]), 32'h0);
    repeat (4) @(posedge hclk);
    xfer(1'b0, fifo_host_pkg::OFS_STATUS, 32'h0, st);
  endtask : cmd
  task automatic put(input logic [8:0] v);
    logic [31:0] d;
    xfer(1'b1, fifo_host_pkg::OFS_WDATA, {23'h0, v}, d);
    cmd(fifo_host_pkg::CTRL_WRITE);
  endtask : put
  task automatic get(input logic [8:0] v);
    logic [31:0] d;
    cmd(fifo_host_pkg::CTRL_READ);
    xfer(1'b0, fifo_host_pkg::OFS_RDATA, 32'h0, d);
    chk({23'h0, d[8:0]}, {23'h0, v});
  endtask : get
  task automatic t_reset;
    chk({28'h0, store_pulse_n, fetch_pulse_n, clear_in_n, retransmit_strobe}, 32'hf);
    chk(32'(expansion_in), 32'h0);
    chk(32'(first_load_select), 32'h1);
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask : t_reset
  task automatic t_clear;
    put(9'h1a5);
    cmd(fifo_host_pkg::CTRL_CLEAR);
    chk(32'(n_cl), 32'h1);
    chk({29'h0, st[3:1]}, 32'h6);
  endtask : t_clear
  task automatic t_data;
    int n;
    put(9'h1a5);
    put(9'h05a);
    put(9'h100);
    get(9'h1a5);
    get(9'h05a);
    get(9'h100);
    n = n_fe;
    cmd(fifo_host_pkg::CTRL_READ);
    chk(32'(n_fe), 32'(n));
    chk(32'(st[fifo_host_pkg::ST_REFUSED]), 32'h1);
  endtask : t_data
  task automatic t_full;
    int n;
    cmd(fifo_host_pkg::CTRL_CLEAR);
    for (int i = 0; i < DEPTH; i++) begin
      put(9'(i + 3));
      if (i == DEPTH / 2 - 1) chk(32'(st[fifo_host_pkg::ST_HALF]), 32'h1);
      if (i == DEPTH / 2) chk(32'(st[fifo_host_pkg::ST_HALF]), 32'h0);
    end
    chk(32'(st[fifo_host_pkg::ST_FULL]), 32'h0);
    n = n_st;
    put(9'h0ff);
    chk(32'(n_st), 32'(n));
    chk(32'(st[fifo_host_pkg::ST_REFUSED]), 32'h1);
    get(9'h003);
    chk(32'(st[fifo_host_pkg::ST_FULL]), 32'h1);
  endtask : t_full
  task automatic t_retx;
    cmd(fifo_host_pkg::CTRL_CLEAR);
    put(9'h011);
    put(9'h022);
    get(9'h011);
    cmd(fifo_host_pkg::CTRL_RETX);
    chk(32'(n_retx), 32'h1);
    get(9'h011);
    get(9'h022);
  endtask : t_retx
  task automatic t_depth;
    mode = 32'h30;
    cmd(fifo_host_pkg::CTRL_CLEAR);
    chk(32'(first_load_select), 32'h0);
    chk(32'(n_cl), 32'h4);
    chk(32'(st[fifo_host_pkg::ST_EMPTY]), 32'h0);
    xfer(1'b0, fifo_host_pkg::OFS_CTRL, 32'h0, st);
    chk(st, 32'h30);
    put(9'h0c3);
    xfer(1'b0, fifo_host_pkg::OFS_WDATA, 32'h0, st);
    chk(st, 32'h0c3);
    cmd(fifo_host_pkg::CTRL_RETX);
    chk(32'(n_retx), 32'h1);
    chk(32'(st[fifo_host_pkg::ST_REFUSED]), 32'h1);
    chk(32'(st[fifo_host_pkg::ST_HALF]), 32'h1);
    mode = 32'h10;
    cmd(fifo_host_pkg::CTRL_READ);
    chk(32'(first_load_select), 32'h1);
    mode = 32'h0;
  endtask : t_depth
  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #100us;
    fails++;
    stop_test();
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    mode = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_reset();
    t_clear();
    t_data();
    t_full();
    t_retx();
    t_depth();
    stop_test();
  end
endmodule : fifo_host_tb
